// >>> rtl/skip_xor_pkg.sv
// Constants and encodings of the skip, table read and exclusive-OR execution unit
// Summary of operation
// - Byte skip: skip next instruction when addressed byte equals zero; flags kept.
// - Any taken skip inserts one dummy cycle, so skips take two cycles.
// - Copy-and-skip: load byte into accumulator, skip when it is zero.
// - Bit skip: skip next instruction when selected bit of byte is zero.
// - Current-page table read: low byte to memory, high byte to table high.
// - Last-page table read: same transfer using the last program page.
// - Memory xor: accumulator xor byte into accumulator, zero flag only.
// - Xor to memory: accumulator xor byte written back to that byte.
// - Immediate xor: accumulator xor immediate into accumulator, zero flag only.
package skip_xor_pkg;

    localparam int          DATA_W          = 8;
    localparam int          PROG_W          = 15;
    localparam int          PROG_ADDR_W     = 12;
    localparam int          DMEM_ADDR_W     = 7;
    localparam logic [7:0]  ACCUMULATOR_RESET = 8'h00;
    localparam logic [7:0]  TABLE_HIGH_RESET  = 8'h00;
    localparam logic [3:0]  LAST_PAGE       = 4'hf;

    typedef enum logic [3:0] {
        OP_NONE          = 4'h0,
        OP_SKIP_ZERO     = 4'h1,
        OP_COPY_SKIP     = 4'h2,
        OP_SKIP_BIT_ZERO = 4'h3,
        OP_TAB_CURRENT   = 4'h4,
        OP_TAB_LAST      = 4'h5,
        OP_XOR_ACC       = 4'h6,
        OP_XOR_MEM       = 4'h7,
        OP_XOR_IMM       = 4'h8
    } op_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TABLE = 2'b01,
        ST_DUMMY = 2'b10
    } state_type;

endpackage

// >>> rtl/xor_zero_unit.sv
// Bitwise exclusive-OR with zero detection
`timescale 1ns/100ps
module xor_zero_unit
    import skip_xor_pkg::*;
(
    input  wire logic [DATA_W-1:0] left,
    input  wire logic [DATA_W-1:0] right,
    output logic      [DATA_W-1:0] result,
    output logic                   is_zero
);
    always_comb begin
        result  = left ^ right;
        is_zero = ((left ^ right) == '0);
    end
endmodule

// >>> rtl/skip_table_xor_instructions.sv
// Execution of skip, table read and exclusive-OR instructions
`timescale 1ns/100ps
module skip_table_xor_instructions
    import skip_xor_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   op_valid,
    input  wire op_type                 op_code,
    input  wire logic [DMEM_ADDR_W-1:0] op_addr,
    input  wire logic [2:0]             op_bit,
    input  wire logic [DATA_W-1:0]      op_imm,
    input  wire logic [PROG_ADDR_W-1:0] pc,
    input  wire logic [DATA_W-1:0]      table_pointer,
    input  wire logic [DATA_W-1:0]      mem_rdata,
    input  wire logic [PROG_W-1:0]      prog_rdata,
    output logic      [DMEM_ADDR_W-1:0] mem_addr,
    output logic                        mem_we,
    output logic      [DATA_W-1:0]      mem_wdata,
    output logic      [PROG_ADDR_W-1:0] prog_addr,
    output logic                        prog_re,
    output logic      [DATA_W-1:0]      accumulator,
    output logic      [DATA_W-1:0]      table_high_byte_reg,
    output logic                        zero_flag,
    output logic                        skip_next,
    output logic                        busy
);

    // ------------------------------------------------------------------
    // State record and datapath
    // ------------------------------------------------------------------
    typedef struct packed {
        state_type                  state;
        logic [DATA_W-1:0]          accum;
        logic [DATA_W-1:0]          table_high;
        logic                       z;
        logic                       we;
        logic [DMEM_ADDR_W-1:0]     waddr;
        logic [DATA_W-1:0]          wdata;
        logic                       skip;
        logic [PROG_ADDR_W-1:0]     paddr;
        logic [DMEM_ADDR_W-1:0]     tdst;
    } core_type;

    core_type cur;
    core_type next_cur;

    logic [DATA_W-1:0] xor_right;
    logic [DATA_W-1:0] xor_result;
    logic              xor_zero;

    assign xor_right = (op_code == OP_XOR_IMM) ? op_imm : mem_rdata;

    xor_zero_unit u_xor (
        .left    (cur.accum),
        .right   (xor_right),
        .result  (xor_result),
        .is_zero (xor_zero)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Data memory address follows the instruction operand during its read cycle
    assign mem_addr            = cur.we ? cur.waddr : op_addr;
    assign mem_we              = cur.we;
    assign mem_wdata           = cur.wdata;
    assign prog_addr           = cur.paddr;
    assign prog_re             = (cur.state == ST_TABLE);
    assign accumulator         = cur.accum;
    assign table_high_byte_reg = cur.table_high;
    assign zero_flag           = cur.z;
    assign skip_next           = cur.skip;
    // Write cycle is busy too: the single memory port cannot read a new operand then
    assign busy                = (cur.state != ST_IDLE) || cur.we;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_cur      = cur;
        next_cur.we   = 1'b0;
        next_cur.skip = 1'b0;
        case (cur.state)
            ST_IDLE: begin
                if (op_valid) begin
                    case (op_code)
                        OP_SKIP_ZERO: begin
                            if (mem_rdata == '0) begin
                                next_cur.skip  = 1'b1;
                                next_cur.state = ST_DUMMY;
                            end
                        end
                        OP_COPY_SKIP: begin
                            next_cur.accum = mem_rdata;
                            if (mem_rdata == '0) begin
                                next_cur.skip  = 1'b1;
                                next_cur.state = ST_DUMMY;
                            end
                        end
                        OP_SKIP_BIT_ZERO: begin
                            if (mem_rdata[op_bit] == 1'b0) begin
                                next_cur.skip  = 1'b1;
                                next_cur.state = ST_DUMMY;
                            end
                        end
                        OP_TAB_CURRENT: begin
                            next_cur.paddr = {pc[PROG_ADDR_W-1:DATA_W], table_pointer};
                            next_cur.tdst  = op_addr;
                            next_cur.state = ST_TABLE;
                        end
                        OP_TAB_LAST: begin
                            next_cur.paddr = {LAST_PAGE, table_pointer};
                            next_cur.tdst  = op_addr;
                            next_cur.state = ST_TABLE;
                        end
                        OP_XOR_ACC: begin
                            next_cur.accum = xor_result;
                            next_cur.z     = xor_zero;
                        end
                        OP_XOR_MEM: begin
                            next_cur.we    = 1'b1;
                            next_cur.waddr = op_addr;
                            next_cur.wdata = xor_result;
                            next_cur.z     = xor_zero;
                        end
                        OP_XOR_IMM: begin
                            next_cur.accum = xor_result;
                            next_cur.z     = xor_zero;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_TABLE: begin
                // Program word is read in the same cycle that the registered address is presented
                next_cur.we    = 1'b1;
                next_cur.waddr = cur.tdst;
                next_cur.wdata = prog_rdata[DATA_W-1:0];
                next_cur.table_high = {1'b0, prog_rdata[PROG_W-1:DATA_W]};
                next_cur.state = ST_IDLE;
            end
            ST_DUMMY: begin
                next_cur.state = ST_IDLE;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '{state: ST_IDLE, accum: ACCUMULATOR_RESET,
                     table_high: TABLE_HIGH_RESET, z: 1'b0,
                     we: 1'b0, waddr: '0, wdata: '0, skip: 1'b0, paddr: '0,
                     tdst: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Skip comes with one busy cycle, and busy drops on the next cycle
    a_skip_dummy: assert property (@(posedge clk) disable iff (rst)
        skip_next |-> busy ##1 !busy) else $error("skip without single dummy cycle");

    a_byte_skip: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_SKIP_ZERO && mem_rdata == 8'h00) |=> skip_next)
        else $error("zero byte did not skip");

    a_byte_noskip: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_SKIP_ZERO && mem_rdata != 8'h00) |=> !skip_next)
        else $error("nonzero byte skipped");

    a_copy_accum: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_COPY_SKIP) |=>
        (accumulator == $past(mem_rdata) && skip_next == ($past(mem_rdata) == 8'h00)))
        else $error("copy and skip wrong");

    a_bit_skip: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_SKIP_BIT_ZERO) |=>
        (skip_next == !$past(mem_rdata[op_bit]))) else $error("bit skip wrong");

    a_tab_write: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && (op_code == OP_TAB_CURRENT || op_code == OP_TAB_LAST))
        |=> prog_re ##1 (mem_we && mem_addr == $past(op_addr, 2)))
        else $error("table read did not store");

    a_tab_last: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_TAB_LAST) |=>
        (prog_addr == {LAST_PAGE, $past(table_pointer)}))
        else $error("last page address wrong");

    a_xor_accum: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_XOR_ACC) |=>
        (accumulator == ($past(accumulator) ^ $past(mem_rdata))))
        else $error("xor accumulator wrong");

    a_xor_mem: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_XOR_MEM) |=>
        (mem_we && mem_wdata == ($past(accumulator) ^ $past(mem_rdata)) && $stable(accumulator)))
        else $error("xor to memory wrong");

    a_xor_zero: assert property (@(posedge clk) disable iff (rst)
        (!busy && op_valid && op_code == OP_XOR_IMM) |=>
        (zero_flag == (($past(accumulator) ^ $past(op_imm)) == 8'h00)))
        else $error("zero flag wrong");

endmodule

// >>> testbench/program_data_memory.sv
// Data memory and program memory on the far side of the execution unit
`timescale 1ns/100ps
module program_data_memory
    import skip_xor_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [DMEM_ADDR_W-1:0] mem_addr,
    input  wire logic                   mem_we,
    input  wire logic [DATA_W-1:0]      mem_wdata,
    input  wire logic [PROG_ADDR_W-1:0] prog_addr,
    input  wire logic                   prog_re,
    output logic      [DATA_W-1:0]      mem_rdata,
    output logic      [PROG_W-1:0]      prog_rdata
);
    logic [DATA_W-1:0] mem [0:127];
    logic [PROG_W-1:0] junk = 15'h2aaa;

    function automatic logic [PROG_W-1:0] word(input logic [PROG_ADDR_W-1:0] a);
        return {a[11:8], a[2:0], a[7:0]} ^ 15'h155c;
    endfunction

    always @(posedge clk) begin
        junk <= ~junk;
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // Program word shown only while a read is active
    assign prog_rdata = prog_re ? word(prog_addr) : junk;
    assign mem_rdata  = mem[mem_addr];
endmodule

// >>> testbench/test_skip_table_xor_instructions.sv
// Self-checking bench for the skip, table read and exclusive-OR unit
`timescale 1ns/100ps
module test_skip_table_xor_instructions;
    import skip_xor_pkg::*;

    logic        clk = 1'b0, rst = 1'b1, op_valid = 1'b0;
    op_type      op_code = OP_NONE;
    logic [6:0]  op_addr = 7'h00, mem_addr;
    logic [2:0]  op_bit = 3'h0;
    logic [7:0]  op_imm = 8'h00, table_pointer = 8'h00, mem_rdata, mem_wdata;
    logic [11:0] pc = 12'h000, prog_addr;
    logic [14:0] prog_rdata;
    logic [7:0]  accumulator, table_high_byte_reg, exp_accum = 8'h00;
    logic        mem_we, prog_re, zero_flag, skip_next, busy, exp_z = 1'b0;
    int          fail_count = 0, total_checks = 0, cycles = 0;

    skip_table_xor_instructions uut (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .pc(pc),
        .table_pointer(table_pointer), .mem_rdata(mem_rdata), .prog_rdata(prog_rdata),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .prog_addr(prog_addr), .prog_re(prog_re), .accumulator(accumulator),
        .table_high_byte_reg(table_high_byte_reg), .zero_flag(zero_flag),
        .skip_next(skip_next), .busy(busy));
    program_data_memory dm (.clk(clk), .mem_addr(mem_addr), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .prog_addr(prog_addr), .prog_re(prog_re),
        .mem_rdata(mem_rdata), .prog_rdata(prog_rdata));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Presents one instruction for one edge, then samples the answer cycle
    task automatic issue(input op_type op, input logic [6:0] a, input logic [7:0] x);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= op;
        op_addr  <= a;
        op_bit   <= x[2:0];
        op_imm   <= x;
        @(posedge clk);
        op_valid <= 1'b0;
        op_code  <= OP_NONE;
        #1;
    endtask

    task automatic skip_case(input op_type op, input logic [2:0] b, input logic [7:0] v,
                             input logic s);
        dm.mem[7'h11] = v;
        if (op == OP_COPY_SKIP) begin
            exp_accum = v;
        end
        issue(op, 7'h11, {5'h00, b});
        check(skip_next, s, "skip");
        check(busy, s, "dummy cycle");
        check(accumulator, exp_accum, "accumulator copy");
        check(zero_flag, exp_z, "flags");
        @(posedge clk);
        #1;
        check({skip_next, busy}, 2'b00, "two cycles");
    endtask

    task automatic xor_case(input op_type op, input logic [7:0] m, input logic [7:0] x);
        logic [7:0] r;
        r = exp_accum ^ ((op == OP_XOR_IMM) ? x : m);
        dm.mem[7'h22] = m;
        exp_z = (r == 8'h00);
        if (op != OP_XOR_MEM) begin
            exp_accum = r;
        end
        issue(op, 7'h22, x);
        check(accumulator, exp_accum, "accumulator xor");
        check(zero_flag, exp_z, "zero flag");
        check(mem_we, op == OP_XOR_MEM, "mem write");
        check(busy, op == OP_XOR_MEM, "write cycle busy");
        @(posedge clk);
        #1;
        check(dm.mem[7'h22], (op == OP_XOR_MEM) ? r : m, "mem value");
    endtask

    task automatic table_case(input op_type op, input logic [3:0] pg, input logic [7:0] tp);
        logic [11:0] a;
        logic [14:0] w;
        a = {(op == OP_TAB_LAST) ? LAST_PAGE : pg, tp};
        w = dm.word(a);
        @(posedge clk);
        pc            <= {pg, 8'h40};
        table_pointer <= tp;
        issue(op, 7'h33, 8'h00);
        check(prog_re, 1'b1, "read strobe");
        check(prog_addr, a, "page and pointer");
        @(posedge clk);
        #1;
        check(mem_we, 1'b1, "low byte write");
        check(busy, 1'b1, "write cycle busy");
        check(table_high_byte_reg, {1'b0, w[14:8]}, "high byte");
        check(zero_flag, exp_z, "flags kept");
        @(posedge clk);
        #1;
        check(dm.mem[7'h33], w[7:0], "low byte");
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({accumulator, table_high_byte_reg}, 16'h0000, "reset regs");
        check({zero_flag, skip_next, busy, mem_we, prog_re}, 5'h00, "reset flags");
        xor_case(OP_XOR_IMM, 8'h00, 8'ha5);
        xor_case(OP_XOR_ACC, 8'ha5, 8'h00);
        xor_case(OP_XOR_MEM, 8'h3c, 8'h00);
        xor_case(OP_XOR_IMM, 8'h00, 8'hff);
        xor_case(OP_XOR_MEM, 8'hff, 8'h00);
        skip_case(OP_SKIP_ZERO, 3'h0, 8'h00, 1'b1);
        skip_case(OP_SKIP_ZERO, 3'h0, 8'h80, 1'b0);
        skip_case(OP_COPY_SKIP, 3'h0, 8'h00, 1'b1);
        skip_case(OP_COPY_SKIP, 3'h0, 8'h01, 1'b0);
        skip_case(OP_SKIP_BIT_ZERO, 3'h7, 8'h7f, 1'b1);
        skip_case(OP_SKIP_BIT_ZERO, 3'h7, 8'h80, 1'b0);
        skip_case(OP_SKIP_BIT_ZERO, 3'h0, 8'hfe, 1'b1);
        table_case(OP_TAB_CURRENT, 4'h3, 8'h5a);
        table_case(OP_TAB_LAST, 4'h3, 8'hff);
        table_case(OP_TAB_CURRENT, 4'hf, 8'h00);
        xor_case(OP_XOR_IMM, 8'h00, 8'h01);
        conclude();
    end
endmodule
